/* sim/bic_board_info_assertions.sv */
`timescale 1ns/1ns
module bic_chk (
  input wire logic clk,
  input wire logic rst,
  input wire bic_pkg::bic_param_req_t param_req,
  input wire bic_pkg::bic_param_rsp_t param_rsp,
  input wire logic group_has_star,
  input wire logic [7:0] interrupt_line,
  input wire logic [2:0] driver_kind,
  input wire logic board_start,
  input wire logic acquisition_done,
  input wire logic powerdown,
  input wire logic board_reset,
  input wire logic sample_memory_valid,
  input wire logic cascade_sync
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cw, pdw, inv;
  assign cw = param_req.wr && param_req.addr == 12'h000;
  assign pdw = cw && param_req.wdata == 32'h0000_001e;
  assign inv = pdw || (cw && param_req.wdata == 32'h0);
  sequence s_cmd(logic [31:0] v);
    cw && param_req.wdata == v;
  endsequence
  a_enter_pd: assert property (s_cmd(32'h1e) |=> powerdown) else $error("no powerdown");
  a_reset_cmd: assert property (s_cmd(32'h0) |=> board_reset && !powerdown)
    else $error("reset command");
  a_start_wake: assert property (board_start && !pdw |=> !powerdown) else $error("wake");
  a_mem_drop: assert property (inv && !acquisition_done |=> !sample_memory_valid)
    else $error("memory valid");
  a_cascade_off: assert property (group_has_star |=> !cascade_sync) else $error("cascade");
  a_read_answer: assert property (param_req.rd |=> param_rsp.rd_valid) else $error("rd");
  a_kind_read: assert property (param_req.rd && param_req.addr == 12'h4c4
    |=> param_rsp.rdata == {29'h0, $past(driver_kind)}) else $error("kind");
  a_irq_read: assert property (param_req.rd && param_req.addr == 12'h8fc
    |=> param_rsp.rdata[7:0] == $past(interrupt_line)) else $error("irq");
  a_ro_write: assert property (param_req.wr && !cw |=> param_rsp.wr_error) else $error("ro");
endmodule
bind bic_board_info bic_chk chk_u (.*);

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, gstar, bstart, adone, pd, brst, mvalid, casc;
  bic_pkg::bic_param_req_t req;
  bic_pkg::bic_param_rsp_t rsp, got, rsp_gen, got_gen;
  logic got_brst;
  bic_pkg::bic_option_pins_t pins;
  logic [7:0] irq;
  logic [2:0] kind;
  int fails, total_checks;
  bic_board_info dut_u (.clk(clk), .rst(rst), .param_req(req), .param_rsp(rsp),
    .option_pins(pins), .group_has_star(gstar), .interrupt_line(irq), .driver_kind(kind),
    .driver_library_version(32'h0000_0101), .kernel_driver_version(32'h0000_0202),
    .board_start(bstart), .acquisition_done(adone), .powerdown(pd), .board_reset(brst),
    .sample_memory_valid(mvalid), .cascade_sync(casc));
  // Generator variant, only its option word is judged
  bic_board_info #(.IS_WAVEFORM_GENERATOR(1'b1)) dut_gen_u (.clk(clk), .rst(rst),
    .param_req(req), .param_rsp(rsp_gen), .option_pins(pins), .group_has_star(gstar),
    .interrupt_line(irq), .driver_kind(kind), .driver_library_version(32'h0000_0101),
    .kernel_driver_version(32'h0000_0202), .board_start(bstart), .acquisition_done(adone),
    .powerdown(), .board_reset(), .sample_memory_valid(), .cascade_sync());
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk);
    #1;
    got = rsp;
    got_gen = rsp_gen;
    got_brst = brst;
    req = '0;
    // Idle edge so a following call never retargets req in the same step
    step();
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input bic_pkg::bic_option_pins_t p);
    pins = p;
    rst = 1;
    repeat (3) step();
    rst = 0;
    repeat (5) step();
  endtask
  task automatic t_options;
    do_reset(8'h04);
    acc(0, 12'h848, 0); chk("star", 32'h0a00, got.rdata);
    do_reset('1);
    acc(0, 12'h848, 0); chk("opts", 32'h2e23, got.rdata);
    chk("opts_gen", 32'h6e23, got_gen.rdata);
    chk("rd_valid", 1, got.rd_valid);
    pins = '0;
    acc(1, 12'h848, 0); chk("wr_err", 1, got.wr_error);
    acc(0, 12'h123, 0); chk("rd_err", 1, got.rd_error);
    chk("rd_zero", 0, got.rdata);
  endtask
  task automatic t_info;
    irq = 8'h0b;
    for (int k = 0; k < 8; k++) begin
      kind = 3'(k);
      acc(0, 12'h4c4, 0); chk("kind", {29'h0, kind}, got.rdata);
    end
    acc(0, 12'h8fc, 0); chk("irq", {24'h0, irq}, got.rdata);
    acc(0, 12'h4b0, 0); chk("lib", 32'h0101, got.rdata);
    acc(0, 12'h4ba, 0); chk("kern", 32'h0202, got.rdata);
  endtask
  task automatic t_cmd;
    adone = 1; step(); adone = 0;
    chk("mv", 1, mvalid);
    acc(1, 12'h000, 32'h1e); chk("pd", 1, pd); chk("mv", 0, mvalid);
    acc(0, 12'h000, 0); chk("cmd", 32'h1e, got.rdata);
    bstart = 1; step(); bstart = 0;
    chk("pd", 0, pd);
    acc(1, 12'h000, 32'h1e);
    acc(1, 12'h000, 32'h0); chk("brst", 1, got_brst); chk("pd", 0, pd);
    chk("mv", 0, mvalid);
    acc(0, 12'h000, 0); chk("brst", 0, got_brst); chk("cmd", 0, got.rdata);
    acc(0, 12'h848, 0); chk("opts", 32'h2e23, got.rdata);
  endtask
  task automatic t_casc;
    gstar = 0; step(); step(); chk("casc", 1, casc);
    gstar = 1; step(); step(); chk("casc", 0, casc);
    gstar = 0;
    do_reset('0);
    chk("casc_nosync", 0, casc);
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {gstar, bstart, adone, irq, kind, fails, total_checks} = '0;
    rst = 1;
    req = '0;
    pins = '0;
    repeat (3000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    #1;
    t_options();
    t_info();
    t_cmd();
    t_casc();
    end_of_test();
  end
endmodule

/* src/bic_board_info.sv */
`timescale 1ns/1ns
module bic_board_info #(
  parameter bit IS_WAVEFORM_GENERATOR = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire bic_pkg::bic_param_req_t param_req,
  output bic_pkg::bic_param_rsp_t param_rsp,
  input wire bic_pkg::bic_option_pins_t option_pins,
  input wire logic group_has_star,
  input wire logic [7:0] interrupt_line,
  input wire logic [2:0] driver_kind,
  input wire logic [31:0] driver_library_version,
  input wire logic [31:0] kernel_driver_version,
  input wire logic board_start,
  input wire logic acquisition_done,
  output logic powerdown,
  output logic board_reset,
  output logic sample_memory_valid,
  output logic cascade_sync
);
  bic_pkg::bic_state_t s;
  bic_pkg::bic_state_t next_s;

  function automatic logic [31:0] build_options(input bic_pkg::bic_option_pins_t p,
                                                input logic wavegen);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[bic_pkg::BIT_SEGMENTED_RECORD] = p.segmented_record_option_flag;
    w[bic_pkg::BIT_DIGITAL_IO] = p.digital_io_option_flag;
    w[bic_pkg::BIT_GATED_SAMPLING] = p.gated_sampling_option_flag;
    w[bic_pkg::BIT_TIME_TAG] = p.time_tag_option_flag;
    // Star module always implies sync capability
    w[bic_pkg::BIT_SYNC_CAPABLE] = p.sync_capable_flag | p.star_distribution_flag;
    w[bic_pkg::BIT_STAR_DISTRIBUTION] = p.star_distribution_flag;
    w[bic_pkg::BIT_EXTRA_IO] = p.extra_io_option_flag;
    w[bic_pkg::BIT_AMP_CALIBRATION] = p.amp_calibration_flag & wavegen;
    return w;
  endfunction

  always_comb begin
    logic cmd_wr;
    cmd_wr = 1'b0;
    next_s = s;
    next_s.strap_meta = option_pins;
    next_s.strap_sync = s.strap_meta;
    next_s.board_reset = 1'b0;
    next_s.rsp.rd_valid = 1'b0;
    next_s.rsp.rd_error = 1'b0;
    next_s.rsp.wr_error = 1'b0;
    if (!s.straps_latched) begin
      if (s.settle_cnt == bic_pkg::STRAP_SETTLE_CYCLES) begin
        // Latched once; later pin changes and reset commands are ignored
        next_s.option_presence = build_options(s.strap_sync, IS_WAVEFORM_GENERATOR);
        next_s.straps_latched = 1'b1;
      end else begin
        next_s.settle_cnt = s.settle_cnt + 2'h1;
      end
    end
    // Sync possible only with the capability; cascade when no star in group
    next_s.cascade_sync = s.option_presence[bic_pkg::BIT_SYNC_CAPABLE] & ~group_has_star;
    if (board_start) begin
      next_s.powerdown = 1'b0;
    end
    if (acquisition_done) begin
      next_s.sample_memory_valid = 1'b1;
    end
    if (param_req.rd) begin
      next_s.rsp.rd_valid = 1'b1;
      unique case (param_req.addr)
        bic_pkg::OFS_BOARD_COMMAND: next_s.rsp.rdata = s.board_command;
        bic_pkg::OFS_DRIVER_LIBRARY_VERSION: next_s.rsp.rdata = driver_library_version;
        bic_pkg::OFS_KERNEL_DRIVER_VERSION: next_s.rsp.rdata = kernel_driver_version;
        bic_pkg::OFS_DRIVER_KIND: next_s.rsp.rdata = {29'h0000_0000, driver_kind};
        bic_pkg::OFS_OPTION_PRESENCE: next_s.rsp.rdata = s.option_presence;
        bic_pkg::OFS_INTERRUPT_LINE_REPORT: next_s.rsp.rdata = {24'h00_0000, interrupt_line};
        default: begin
          next_s.rsp.rdata = 32'h0000_0000;
          next_s.rsp.rd_error = 1'b1;
        end
      endcase
    end
    if (param_req.wr) begin
      if (param_req.addr == bic_pkg::OFS_BOARD_COMMAND) begin
        cmd_wr = 1'b1;
        next_s.board_command = param_req.wdata;
      end else begin
        // Read-only or unmapped: value dropped
        next_s.rsp.wr_error = 1'b1;
      end
    end
    if (cmd_wr && param_req.wdata == bic_pkg::LOW_POWER_COMMAND) begin
      next_s.powerdown = 1'b1;
      next_s.sample_memory_valid = 1'b0;
    end
    if (cmd_wr && param_req.wdata == bic_pkg::FULL_RESET_COMMAND) begin
      next_s.board_reset = 1'b1;
      next_s.powerdown = 1'b0;
      next_s.board_command = bic_pkg::BOARD_COMMAND_RESET;
      next_s.sample_memory_valid = 1'b0;
    end
    // Memory filled in the same cycle as the invalidating command stays valid
    if (acquisition_done) begin
      next_s.sample_memory_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign param_rsp = s.rsp;
  assign powerdown = s.powerdown;
  assign board_reset = s.board_reset;
  assign sample_memory_valid = s.sample_memory_valid;
  assign cascade_sync = s.cascade_sync;
endmodule

/* src/bic_pkg.sv */
// Functional notes
// - Read-only 32-bit option word, one bit per fitted option, testable by masking.
// - Bit weight 1 flags segmented record; weight 2 flags digital I/O.
// - Bit weight 32 flags gated sampling; weight 1024 flags time tag option.
// - Weight 512 set when any sync capability fitted; without it no sync.
// - Star distribution module sets weight 2048 and the sync flag too.
// - Group without any star distribution module synchronizes by cascading.
// - Weight 8192 flags extra I/O; 16384 amp calibration, generators only.
// - Read-only parameter reports the interrupt line actually in use.
// - Read-only driver kind code 0 to 7; 5 is 64-bit for 64-bit.
// - Command register is read/write; code 30 enters low-power powerdown.
// - Powerdown ends on reset command or on board start.
// - Command code 0 does software and hardware reset, settings to defaults.
// - Powerdown or reset marks sample memory invalid; host must not read. Code keeps it valid when acquisition_done comes in the same cycle.
package bic_pkg;
  localparam int unsigned PARAM_AW = 12;
  localparam logic [11:0] OFS_BOARD_COMMAND = 12'h000;
  localparam logic [11:0] OFS_DRIVER_LIBRARY_VERSION = 12'h4b0;
  localparam logic [11:0] OFS_KERNEL_DRIVER_VERSION = 12'h4ba;
  localparam logic [11:0] OFS_DRIVER_KIND = 12'h4c4;
  localparam logic [11:0] OFS_OPTION_PRESENCE = 12'h848;
  localparam logic [11:0] OFS_INTERRUPT_LINE_REPORT = 12'h8fc;

  localparam logic [31:0] FULL_RESET_COMMAND = 32'h0000_0000;
  localparam logic [31:0] LOW_POWER_COMMAND = 32'h0000_001e;
  localparam logic [31:0] BOARD_COMMAND_RESET = 32'h0000_0000;

  localparam int unsigned BIT_SEGMENTED_RECORD = 0;
  localparam int unsigned BIT_DIGITAL_IO = 1;
  localparam int unsigned BIT_GATED_SAMPLING = 5;
  localparam int unsigned BIT_SYNC_CAPABLE = 9;
  localparam int unsigned BIT_TIME_TAG = 10;
  localparam int unsigned BIT_STAR_DISTRIBUTION = 11;
  localparam int unsigned BIT_EXTRA_IO = 13;
  localparam int unsigned BIT_AMP_CALIBRATION = 14;

  // Edges after release before the synchronised straps are latched
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  typedef struct packed {
    logic segmented_record_option_flag;
    logic digital_io_option_flag;
    logic gated_sampling_option_flag;
    logic sync_capable_flag;
    logic time_tag_option_flag;
    logic star_distribution_flag;
    logic extra_io_option_flag;
    logic amp_calibration_flag;
  } bic_option_pins_t;

  typedef struct packed {
    logic [PARAM_AW-1:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } bic_param_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic rd_valid;
    logic rd_error;
    logic wr_error;
  } bic_param_rsp_t;

  typedef struct packed {
    bic_option_pins_t strap_meta;
    bic_option_pins_t strap_sync;
    logic [1:0] settle_cnt;
    logic straps_latched;
    logic [31:0] option_presence;
    logic [31:0] board_command;
    logic powerdown;
    logic board_reset;
    logic sample_memory_valid;
    logic cascade_sync;
    bic_param_rsp_t rsp;
  } bic_state_t;
endpackage
